/* File: cdpd_consts.svh */
// Constants for the cascaded divider and phase delay block
`ifndef CDPD_CONSTS_SVH
`define CDPD_CONSTS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define IDX_OUTA_BYP    9'h0A0
`define IDX_OUTA_RAMP   9'h0A1
`define IDX_OUTA_FRAC   9'h0A2
`define IDX_OUTB_BYP    9'h0A3
`define IDX_OUTB_RAMP   9'h0A4
`define IDX_OUTB_FRAC   9'h0A5
`define IDX_OUTC_BYP    9'h0A6
`define IDX_OUTC_RAMP   9'h0A7
`define IDX_OUTC_FRAC   9'h0A8
`define IDX_OUTD_BYP    9'h0A9
`define IDX_OUTD_RAMP   9'h0AA
`define IDX_OUTD_FRAC   9'h0AB
`define IDX_D3_S1_CNT   9'h199
`define IDX_D3_PHASE    9'h19A
`define IDX_D3_S2_CNT   9'h19B
`define IDX_D3_START    9'h19C
`define IDX_D4_S1_CNT   9'h19E
`define IDX_D4_PHASE    9'h19F
`define IDX_D4_S2_CNT   9'h1A0
`define IDX_D4_START    9'h1A1
`define IDX_D3_CTRL     9'h1B0
`define IDX_D4_CTRL     9'h1B1
`define IDX_SYNC_CTRL   9'h1B2
`define IDX_STATUS      9'h1B3

// ************************************************************
// Slots, fields and reset values
// ************************************************************
`define SLOT_FINE_BASE  5'h00
`define SLOT_DIV_BASE   5'h0C
`define SLOT_CTRL_BASE  5'h14
`define SLOT_SYNC       5'h16
`define SLOT_STATUS     5'h17
`define SLOT_STORED     23
`define SLOT_NONE       5'h1F
`define REG_RESET       8'h00
`define CTRL_BYP1_BIT   0
`define CTRL_BYP2_BIT   1
`define CTRL_DUTY_CORRECTION_DISABLE_BIT 2
`define CTRL_NOSYNC_BIT 3
`define SYNC_SOFT_BIT   0
`define PHASE_HI_LIMIT  5'h10

`endif

/* File: cdpd_pkg.sv */
// Types shared by the cascaded divider and phase delay block
package cdpd_pkg;

  // ************************************************************
  // Stage configuration and control
  // ************************************************************
  typedef struct packed {
    logic       initial_level_high;
    logic [3:0] phase_step_count;
    logic [3:0] low_count;
    logic [3:0] high_count;
  } stage_cfg_t;

  typedef struct packed {
    logic bypass;
    logic duty_correction_disable;
    logic hold;
  } stage_ctl_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } clk_edge_t;

  typedef struct packed {
    logic       delay_bypass;
    logic [2:0] ramp_caps;
    logic [2:0] ramp_current;
    logic [5:0] delay_fraction;
  } fine_delay_t;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_HIGH  = 3'b010,
    ST_FALLW = 3'b011,
    ST_LOW   = 3'b100
  } stage_state_t;

endpackage : cdpd_pkg

/* File: divider_stage.sv */
// One programmable divider stage with duty correction and phase delay
`timescale 1ns/1ps
`include "cdpd_consts.svh"
module divider_stage (
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire cdpd_pkg::stage_cfg_t cfg_i,
  input  wire cdpd_pkg::stage_ctl_t ctl_i,
  input  wire cdpd_pkg::clk_edge_t  in_i,
  output      cdpd_pkg::clk_edge_t  out_o
);

  cdpd_pkg::stage_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic       level_q, level_d;
  logic       rise_q, rise_d;
  logic       fall_q, fall_d;
  logic [4:0] phase;
  logic [4:0] start_delay;
  logic       odd_dcc;

  // ************************************************************
  // Decode
  // ************************************************************
  assign phase = {cfg_i.initial_level_high, cfg_i.phase_step_count};
  assign start_delay = (phase < `PHASE_HI_LIMIT) ? phase :
                       5'({1'b0, cfg_i.phase_step_count}
                          + {1'b0, cfg_i.low_count} + 5'h01);
  // Odd ratio is only recognised in the low = high + 1 form
  assign odd_dcc = !ctl_i.duty_correction_disable &&
                   ({1'b0, cfg_i.low_count} ==
                    5'({1'b0, cfg_i.high_count} + 5'h01));

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    level_d = level_q;
    rise_d  = 1'b0;
    fall_d  = 1'b0;
    if (ctl_i.bypass) begin
      level_d = in_i.level;
      rise_d  = in_i.rise;
      fall_d  = in_i.fall;
      state_d = cdpd_pkg::ST_HOLD;
    end else if (ctl_i.hold) begin
      state_d = cdpd_pkg::ST_HOLD;
      level_d = cfg_i.initial_level_high;
      rise_d  = cfg_i.initial_level_high & ~level_q;
      fall_d  = ~cfg_i.initial_level_high & level_q;
    end else begin
      case (state_q)
        cdpd_pkg::ST_HOLD: begin
          state_d = cdpd_pkg::ST_WAIT;
          cnt_d   = start_delay;
        end
        cdpd_pkg::ST_WAIT, cdpd_pkg::ST_LOW: begin
          if (in_i.rise) begin
            if (cnt_q == 5'h00) begin
              state_d = cdpd_pkg::ST_HIGH;
              cnt_d   = {1'b0, cfg_i.high_count};
              level_d = 1'b1;
              rise_d  = ~level_q;
              fall_d  = 1'b0;
            end else begin
              cnt_d = 5'(cnt_q - 5'h01);
            end
          end
        end
        cdpd_pkg::ST_HIGH: begin
          if (in_i.rise) begin
            if (cnt_q != 5'h00) begin
              cnt_d = 5'(cnt_q - 5'h01);
            end else if (odd_dcc) begin
              state_d = cdpd_pkg::ST_FALLW;
            end else begin
              state_d = cdpd_pkg::ST_LOW;
              cnt_d   = {1'b0, cfg_i.low_count};
              level_d = 1'b0;
              fall_d  = 1'b1;
            end
          end
        end
        cdpd_pkg::ST_FALLW: begin
          // Half-cycle stretch taken from the input falling edge
          if (in_i.fall) begin
            // Low runs m+1 rises so the period stays n+m+2 input cycles
            state_d = cdpd_pkg::ST_LOW;
            cnt_d   = {1'b0, cfg_i.low_count};
            level_d = 1'b0;
            fall_d  = 1'b1;
          end
        end
        default: begin
          state_d = cdpd_pkg::ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= cdpd_pkg::ST_HOLD;
      cnt_q   <= 5'h00;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      level_q <= level_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

  assign out_o = '{level: level_q, rise: rise_q, fall: fall_q};

endmodule : divider_stage

/* File: cascaded_divider_phase_delay.sv */
// APB register file, two cascaded divider pairs and fine delay fields
`timescale 1ns/1ps
`include "cdpd_consts.svh"
module cascaded_divider_phase_delay #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_W-1:0]     paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output      logic [31:0]           prdata_o,
  output      logic                  pready_o,
  output      logic                  pslverr_o,
  input  wire logic                  src_clk_i,
  input  wire logic                  sync_n_i,
  output      logic                  delayed_output_a_o,
  output      logic                  delayed_output_b_o,
  output      logic                  delayed_output_c_o,
  output      logic                  delayed_output_d_o,
  output      cdpd_pkg::fine_delay_t fine_delay_a_o,
  output      cdpd_pkg::fine_delay_t fine_delay_b_o,
  output      cdpd_pkg::fine_delay_t fine_delay_c_o,
  output      cdpd_pkg::fine_delay_t fine_delay_d_o
);

  // ************************************************************
  // Address map
  // ************************************************************
  function automatic logic [4:0] slot_of(input logic [8:0] idx);
    case (idx)
      `IDX_OUTA_BYP:  slot_of = 5'h00;
      `IDX_OUTA_RAMP: slot_of = 5'h01;
      `IDX_OUTA_FRAC: slot_of = 5'h02;
      `IDX_OUTB_BYP:  slot_of = 5'h03;
      `IDX_OUTB_RAMP: slot_of = 5'h04;
      `IDX_OUTB_FRAC: slot_of = 5'h05;
      `IDX_OUTC_BYP:  slot_of = 5'h06;
      `IDX_OUTC_RAMP: slot_of = 5'h07;
      `IDX_OUTC_FRAC: slot_of = 5'h08;
      `IDX_OUTD_BYP:  slot_of = 5'h09;
      `IDX_OUTD_RAMP: slot_of = 5'h0A;
      `IDX_OUTD_FRAC: slot_of = 5'h0B;
      `IDX_D3_S1_CNT: slot_of = 5'h0C;
      `IDX_D3_PHASE:  slot_of = 5'h0D;
      `IDX_D3_S2_CNT: slot_of = 5'h0E;
      `IDX_D3_START:  slot_of = 5'h0F;
      `IDX_D4_S1_CNT: slot_of = 5'h10;
      `IDX_D4_PHASE:  slot_of = 5'h11;
      `IDX_D4_S2_CNT: slot_of = 5'h12;
      `IDX_D4_START:  slot_of = 5'h13;
      `IDX_D3_CTRL:   slot_of = 5'h14;
      `IDX_D4_CTRL:   slot_of = 5'h15;
      `IDX_SYNC_CTRL: slot_of = `SLOT_SYNC;
      `IDX_STATUS:    slot_of = `SLOT_STATUS;
      default:        slot_of = `SLOT_NONE;
    endcase
  endfunction : slot_of

  logic [7:0] regs_q [`SLOT_STORED];
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  wire         addr_ok;
  wire  [4:0]  acc_slot;
  wire         slot_ok;
  wire         setup_ph;
  wire         access_done;
  wire         wr_en;
  wire  [7:0]  status_byte;
  wire  [7:0]  rd_byte;

  // Word aligned accesses inside the index window only
  assign addr_ok  = (paddr_i[1:0] == 2'b00) &&
                    (paddr_i[ADDR_W-1:11] == '0);
  assign acc_slot = addr_ok ? slot_of(paddr_i[10:2]) : `SLOT_NONE;
  assign slot_ok  = (acc_slot != `SLOT_NONE);
  assign setup_ph = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready_q;
  // Status is read only; writes to it are dropped silently
  assign wr_en    = access_done && pwrite_i && slot_ok &&
                    (acc_slot != `SLOT_STATUS) && pstrb_i[0];
  assign rd_byte  = (acc_slot == `SLOT_STATUS) ? status_byte :
                    slot_ok ? regs_q[acc_slot] : `REG_RESET;

  // ************************************************************
  // APB slave: answers in the first access cycle
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready_q  <= 1'b1;
      pslverr_q <= !slot_ok;
      prdata_q  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `SLOT_STORED; i++) begin
        regs_q[i] <= `REG_RESET;
      end
    end else if (wr_en) begin
      regs_q[acc_slot] <= pwdata_i[7:0];
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] src_sync_q;
  logic       src_prev_q;
  logic [1:0] sync_pin_q;
  cdpd_pkg::clk_edge_t src_edge;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      src_sync_q <= 2'b00;
      src_prev_q <= 1'b0;
      sync_pin_q <= 2'b11;
    end else begin
      src_sync_q <= {src_sync_q[0], src_clk_i};
      src_prev_q <= src_sync_q[1];
      sync_pin_q <= {sync_pin_q[0], sync_n_i};
    end
  end

  // The source clock must stay well below half of mclk to be seen
  assign src_edge = '{level: src_sync_q[1],
                      rise:  src_sync_q[1] & ~src_prev_q,
                      fall:  ~src_sync_q[1] & src_prev_q};

  wire sync_active;
  assign sync_active = !sync_pin_q[1] ||
                       regs_q[`SLOT_SYNC][`SYNC_SOFT_BIT];

  // ************************************************************
  // Divider pairs
  // ************************************************************
  cdpd_pkg::clk_edge_t div_out [2];
  logic [1:0]          div_hold;

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_div
      localparam int BASE = `SLOT_DIV_BASE + 4 * d;
      localparam int CTRL = `SLOT_CTRL_BASE + d;
      cdpd_pkg::stage_cfg_t cfg1;
      cdpd_pkg::stage_cfg_t cfg2;
      cdpd_pkg::stage_ctl_t ctl1;
      cdpd_pkg::stage_ctl_t ctl2;
      cdpd_pkg::clk_edge_t  mid;
      cdpd_pkg::clk_edge_t  src_in;
      wire                  hold;

      assign cfg1 = '{initial_level_high: regs_q[BASE+3][0],
                      phase_step_count:   regs_q[BASE+1][3:0],
                      low_count:          regs_q[BASE][7:4],
                      high_count:         regs_q[BASE][3:0]};
      assign cfg2 = '{initial_level_high: regs_q[BASE+3][1],
                      phase_step_count:   regs_q[BASE+1][7:4],
                      low_count:          regs_q[BASE+2][7:4],
                      high_count:         regs_q[BASE+2][3:0]};
      // Excluded channels keep running through a sync
      assign hold = sync_active &&
                    !regs_q[CTRL][`CTRL_NOSYNC_BIT];
      // A bypassed first stage would pass the free clock through a sync,
      // so its input is parked at the start level while held
      assign src_in = hold ? '{level: cfg1.initial_level_high,
                               rise:  1'b0,
                               fall:  1'b0} : src_edge;
      assign ctl1 = '{bypass: regs_q[CTRL][`CTRL_BYP1_BIT],
                      duty_correction_disable:
                        regs_q[CTRL][`CTRL_DUTY_CORRECTION_DISABLE_BIT],
                      hold: hold};
      assign ctl2 = '{bypass: regs_q[CTRL][`CTRL_BYP2_BIT],
                      duty_correction_disable:
                        regs_q[CTRL][`CTRL_DUTY_CORRECTION_DISABLE_BIT],
                      hold: hold};

      divider_stage u_stage1 (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .cfg_i     (cfg1),
        .ctl_i     (ctl1),
        .in_i      (src_in),
        .out_o     (mid)
      );

      // Second stage counts the first stage's output edges
      divider_stage u_stage2 (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .cfg_i     (cfg2),
        .ctl_i     (ctl2),
        .in_i      (mid),
        .out_o     (div_out[d])
      );

      assign div_hold[d] = hold;
    end
  endgenerate

  assign status_byte = {4'h0, div_hold, div_out[1].level, div_out[0].level};

  // ************************************************************
  // Output registers
  // ************************************************************
  // Analog fine delay is outside this logic; the fields are handed on as
  // written, and keeping the delay under half a period is up to software
  function automatic cdpd_pkg::fine_delay_t fine_of(input int base);
    fine_of = '{delay_bypass:   regs_q[base][0],
                ramp_caps:      regs_q[base+1][5:3],
                ramp_current:   regs_q[base+1][2:0],
                delay_fraction: regs_q[base+2][5:0]};
  endfunction : fine_of

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      delayed_output_a_o <= 1'b0;
      delayed_output_b_o <= 1'b0;
      delayed_output_c_o <= 1'b0;
      delayed_output_d_o <= 1'b0;
      fine_delay_a_o     <= '0;
      fine_delay_b_o     <= '0;
      fine_delay_c_o     <= '0;
      fine_delay_d_o     <= '0;
    end else begin
      delayed_output_a_o <= div_out[0].level;
      delayed_output_b_o <= div_out[0].level;
      delayed_output_c_o <= div_out[1].level;
      delayed_output_d_o <= div_out[1].level;
      fine_delay_a_o     <= fine_of(0);
      fine_delay_b_o     <= fine_of(3);
      fine_delay_c_o     <= fine_of(6);
      fine_delay_d_o     <= fine_of(9);
    end
  end

endmodule : cascaded_divider_phase_delay

/* File: cdpd_sva.sv */
// Checker for the register bus, fine delay copies and sync hold
`timescale 1ns/1ps
module cdpd_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic                  mclk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [ADDR_W-1:0]     paddr_i,
  input wire logic [31:0]           pwdata_i,
  input wire logic [3:0]            pstrb_i,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic                  sync_n_i,
  input wire logic                  delayed_output_a_o,
  input wire logic                  delayed_output_b_o,
  input wire cdpd_pkg::fine_delay_t fine_delay_a_o
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Committed write to the output A fraction register
  wire logic frac_wr = psel_i && penable_i && pready_o && pwrite_i
                       && pstrb_i[0] && paddr_i[10:0] == 11'h288;

  ans_next_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  rdy_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  upper_zero_a: assert property (pready_o && !pwrite_i
    |-> prdata_o[31:8] == 24'h000000) else $error("read data upper set");
  err_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  misalign_a: assert property (psel_i && !penable_i
    && paddr_i[1:0] != 2'h0 |=> pslverr_o) else $error("misaligned taken");
  frac_copy_a: assert property (frac_wr |=> ##1
    fine_delay_a_o.delay_fraction == $past(pwdata_i[5:0], 2))
    else $error("fraction copy wrong");
  pair_same_a: assert property (
    delayed_output_a_o == delayed_output_b_o) else $error("pair differs");
  sync_hold_a: assert property (!sync_n_i [*8]
    |-> $stable(delayed_output_a_o)) else $error("output moves in sync");

  cover property (frac_wr);
  cover property (pslverr_o);
  cover property ($rose(delayed_output_a_o));
endmodule : cdpd_sva

/* File: tb_top.sv */
// Self-checking bench for the cascaded divider and phase delay block
`timescale 1ns/1ps
module tb_top;
  logic                  mclk_i    = 1'b0;
  logic                  sys_rst_i = 1'b1;
  logic                  psel_i    = 1'b0;
  logic                  penable_i = 1'b0;
  logic                  pwrite_i  = 1'b0;
  logic [11:0]           paddr_i   = 12'h000;
  logic [31:0]           pwdata_i  = 32'h00000000;
  logic [3:0]            pstrb_i   = 4'hF;
  logic                  src_clk_i = 1'b0;
  logic                  sync_n_i  = 1'b1;
  logic [31:0]           prdata_o;
  logic                  pready_o;
  logic                  pslverr_o;
  logic [3:0]            outs;
  cdpd_pkg::fine_delay_t fd [4];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int src_hi = 4;
  int src_lo = 4;
  int src_cnt = 0;
  // Fractions kept at or below 47
  logic [7:0] pat [12] = '{8'h01, 8'h2B, 8'h2F, 8'h00, 8'h1E, 8'h15,
                           8'h01, 8'h3F, 8'h00, 8'h00, 8'h07, 8'h2A};

  cascaded_divider_phase_delay dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .src_clk_i(src_clk_i), .sync_n_i(sync_n_i),
    .delayed_output_a_o(outs[0]), .delayed_output_b_o(outs[1]),
    .delayed_output_c_o(outs[2]), .delayed_output_d_o(outs[3]),
    .fine_delay_a_o(fd[0]), .fine_delay_b_o(fd[1]),
    .fine_delay_c_o(fd[2]), .fine_delay_d_o(fd[3]));

  // ************************************************************
  // Clocks and timeout
  // ************************************************************
  always #5 mclk_i = ~mclk_i;
  // Source clock kept well below a quarter of the system clock
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (src_cnt >= (src_clk_i ? src_hi : src_lo) - 1) begin
      src_clk_i <= ~src_clk_i;
      src_cnt <= 0;
    end else begin
      src_cnt <= src_cnt + 1;
    end
    if (cyc == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
           output logic [7:0] rd, output logic er);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, wd};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata_o[7:0];
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task wr(input logic [8:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, {1'b0, i, 2'b00}, d, r, e);
  endtask : wr

  task rdc(input logic [8:0] i, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'b0, {1'b0, i, 2'b00}, 8'h00, r, e);
    chk({24'h000000, r}, {24'h000000, x});
  endtask : rdc

  task wait_lvl(input int s, input logic v);
    int n;
    n = 0;
    while (outs[s] !== v && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask : wait_lvl

  // Counts run in the high nibble (low cycles) and low nibble (high)
  task cfg(input logic ch, input logic [7:0] c1, input logic [7:0] c2,
           input logic [7:0] ph, input logic [7:0] st, input logic [7:0] ct);
    logic [8:0] b;
    b = ch ? 9'h19E : 9'h199;
    wr(b, c1);
    wr(b + 9'h001, ph);
    wr(b + 9'h002, c2);
    wr(b + 9'h003, st);
    wr(9'h1B0 + {8'h00, ch}, ct);
  endtask : cfg

  // Restarts all channels not excluded from sync so a new setting takes a clean phase
  task sync_do(input logic en, input logic xa, input logic xc);
    @(posedge mclk_i);
    sync_n_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    if (en) chk({31'h0, outs[0]}, {31'h0, xa});
    if (en) chk({31'h0, outs[2]}, {31'h0, xc});
    if (en) chk({31'h0, outs[1]}, {31'h0, xa});
    if (en) chk({31'h0, outs[3]}, {31'h0, xc});
    sync_n_i <= 1'b1;
    repeat (600) @(posedge mclk_i);
  endtask : sync_do

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_regs();
    for (int i = 0; i < 4; i++) begin
      rdc(9'h199 + 9'(i), 8'h00);
      rdc(9'h19E + 9'(i), 8'h00);
    end
    for (int i = 0; i < 12; i++) begin
      rdc(9'h0A0 + 9'(i), 8'h00);
      wr(9'h0A0 + 9'(i), pat[i]);
      rdc(9'h0A0 + 9'(i), pat[i]);
    end
    for (int k = 0; k < 4; k++)
      chk({19'h0, fd[k]}, {19'h0, pat[3*k][0], pat[3*k+1][5:0],
          pat[3*k+2][5:0]});
  endtask : t_regs

  task t_errs();
    logic [7:0] r;
    logic e;
    apb(1'b0, 12'h674, 8'h00, r, e);
    chk({23'h0, e, r}, {23'h0, 1'b1, 8'h00});
    apb(1'b1, 12'h289, 8'h11, r, e);
    chk({31'h0, e}, 32'h00000001);
    pstrb_i <= 4'h0;
    wr(9'h0A2, 8'h11);
    pstrb_i <= 4'hF;
    rdc(9'h0A2, 8'h2F);
  endtask : t_errs

  task run_div(input logic [7:0] c1, input logic [7:0] c2,
               input logic [7:0] ct, input int hi, input int lo,
               input int ep, input int eh);
    int t0;
    int h;
    src_hi = hi;
    src_lo = lo;
    cfg(1'b0, c1, c2, 8'h00, 8'h00, ct);
    sync_do(1'b0, 1'b0, 1'b0);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    t0 = cyc;
    wait_lvl(0, 1'b0);
    h = cyc - t0;
    wait_lvl(0, 1'b1);
    chk(32'(cyc - t0), 32'(ep));
    chk(32'(h), 32'(eh));
  endtask : run_div

  task t_div();
    run_div(8'h11, 8'h00, 8'h02, 3, 5, 32, 16);
    run_div(8'h21, 8'h00, 8'h02, 4, 4, 40, 20);
    run_div(8'h21, 8'h00, 8'h02, 3, 5, 40, 19);
    run_div(8'h21, 8'h00, 8'h06, 4, 4, 40, 16);
    run_div(8'h00, 8'h00, 8'h03, 3, 5, 8, 3);
    run_div(8'h10, 8'h00, 8'h00, 3, 5, 48, 24);
    run_div(8'h10, 8'h10, 8'h00, 3, 5, 72, 35);
    run_div(8'h00, 8'h11, 8'h01, 3, 5, 32, 16);
  endtask : t_div

  // Steady-state skew between the two dividers, period 64 cycles
  task run_phase(input logic [7:0] ph, input logic [7:0] st, input int ex);
    int t0;
    src_hi = 4;
    src_lo = 4;
    cfg(1'b0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h02);
    cfg(1'b1, 8'h33, 8'h00, ph, st, 8'h02);
    sync_do(1'b1, 1'b0, st[0]);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    t0 = cyc;
    wait_lvl(2, 1'b0);
    wait_lvl(2, 1'b1);
    chk(32'((cyc - t0) % 64), 32'(ex));
  endtask : run_phase

  task t_phase();
    run_phase(8'h03, 8'h00, 24);
    run_phase(8'h02, 8'h01, 48);
  endtask : t_phase

  // Soft sync holds both channels; an excluded one runs on
  task t_soft();
    logic [7:0] r;
    logic e;
    apb(1'b1, 12'h6CC, 8'hFF, r, e);
    chk({31'h0, e}, 32'h00000000);
    wr(9'h1B2, 8'h01);
    repeat (8) @(posedge mclk_i);
    rdc(9'h1B3, 8'h0E);
    wr(9'h1B1, 8'h0A);
    apb(1'b0, 12'h6CC, 8'h00, r, e);
    chk({30'h0, r[3:2]}, 32'h00000001);
    wr(9'h1B2, 8'h00);
  endtask : t_soft

  task tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_errs();
    t_div();
    t_phase();
    t_soft();
    tally_and_finish();
  end
endmodule : tb_top

bind cascaded_divider_phase_delay cdpd_sva #(.ADDR_W(ADDR_W)) u_sva (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sync_n_i(sync_n_i),
  .delayed_output_a_o(delayed_output_a_o),
  .delayed_output_b_o(delayed_output_b_o),
  .fine_delay_a_o(fine_delay_a_o));
